// ---- design/tpo_unit.sv ----
// timed pattern output unit with AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module tpo_unit (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // compare match pulses of timer channels 0 to 2
  input wire logic [tpo_pkg::CHANNELS-1:0] CMP_MATCH,
  // pattern outputs and their enables
  output logic [7:0] PORTA_OUT,
  output logic [7:0] PORTB_OUT,
  output logic [7:0] PORTA_OE,
  output logic [7:0] PORTB_OE,
  // AXI4-Lite write address and data
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [tpo_pkg::ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [tpo_pkg::DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [tpo_pkg::ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [tpo_pkg::DATA_W-1:0] RDATA,
  output logic [1:0] RRESP
);
  import tpo_pkg::*;

  logic [7:0] trig_sel_reg, trig_sel_next;
  logic [7:0] en_hi_reg, en_hi_next;
  logic [7:0] en_lo_reg, en_lo_next;
  logic [15:0] nd_reg, nd_next;
  logic [15:0] port_reg, port_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic [IDX_W-1:0] waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [GROUPS-1:0] fire;
  logic lo_same, hi_same, wr_do;
  logic [IDX_W-1:0] ridx;

  // per-group trigger selection from its two-bit field
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_trig
      logic [1:0] sel;
      assign sel = trig_sel_reg[2*g+1:2*g];
      assign fire[g] = sel[SEL_HI_BIT] ? CMP_MATCH[2] :
        (sel[SEL_LO_BIT] ? CMP_MATCH[1] : CMP_MATCH[0]);
    end
  endgenerate

  assign lo_same = trig_sel_reg[1:0] == trig_sel_reg[3:2];
  assign hi_same = trig_sel_reg[5:4] == trig_sel_reg[7:6];
  assign wr_do = !awready_reg && !wready_reg && !bvalid_reg;
  assign ridx = ARADDR[ADDR_W-1:2];

  // pattern transfer to the ports
  always_comb begin
    port_next = port_reg;
    for (int b = 0; b < 16; b++) begin
      if (fire[b/GRP_BITS] && (b < 8 ? en_lo_reg[b%8] : en_hi_reg[b%8])) begin
        port_next[b] = nd_reg[b];
      end
    end
  end

  // register writes
  always_comb begin
    trig_sel_next = trig_sel_reg;
    en_hi_next = en_hi_reg;
    en_lo_next = en_lo_reg;
    nd_next = nd_reg;
    bresp_next = bresp_reg;
    if (wr_do) begin
      bresp_next = RESP_OKAY;
      if (waddr_reg == IDX_TRIG_SEL) begin
        if (wstrb_reg) trig_sel_next = wdata_reg;
      end else if (waddr_reg == IDX_EN_HI) begin
        if (wstrb_reg) en_hi_next = wdata_reg;
      end else if (waddr_reg == IDX_EN_LO) begin
        if (wstrb_reg) en_lo_next = wdata_reg;
      end else if (waddr_reg == IDX_ND_LO_A) begin
        if (wstrb_reg) begin
          nd_next[7:4] = wdata_reg[7:4];
          if (lo_same) nd_next[3:0] = wdata_reg[3:0];
        end
      end else if (waddr_reg == IDX_ND_LO_B) begin
        if (wstrb_reg && !lo_same) nd_next[3:0] = wdata_reg[3:0];
      end else if (waddr_reg == IDX_ND_HI_A) begin
        if (wstrb_reg) begin
          nd_next[15:12] = wdata_reg[7:4];
          if (hi_same) nd_next[11:8] = wdata_reg[3:0];
        end
      end else if (waddr_reg == IDX_ND_HI_B) begin
        if (wstrb_reg && !hi_same) nd_next[11:8] = wdata_reg[3:0];
      end else if (waddr_reg != IDX_PORT_STAT) begin
        bresp_next = RESP_SLVERR;
      end
    end
  end

  // write channel handshakes
  always_comb begin
    awready_next = awready_reg;
    wready_next = wready_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    if (AWVALID && awready_reg) begin
      awready_next = 1'b0;
      waddr_next = AWADDR[ADDR_W-1:2];
    end
    if (WVALID && wready_reg) begin
      wready_next = 1'b0;
      wdata_next = WDATA[7:0];
      wstrb_next = WSTRB[0];
    end
    if (wr_do) begin
      bvalid_next = 1'b1;
    end
    if (bvalid_reg && BREADY) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
  end

  // read channel
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ARVALID && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 8'h00;
      if (ridx == IDX_TRIG_SEL) begin
        rdata_next = trig_sel_reg;
      end else if (ridx == IDX_EN_HI) begin
        rdata_next = en_hi_reg;
      end else if (ridx == IDX_EN_LO) begin
        rdata_next = en_lo_reg;
      end else if (ridx == IDX_ND_LO_A) begin
        rdata_next = {nd_reg[7:4], lo_same ? nd_reg[3:0] : NIB_ONES};
      end else if (ridx == IDX_ND_LO_B) begin
        rdata_next = lo_same ? BYTE_ONES : {NIB_ONES, nd_reg[3:0]};
      end else if (ridx == IDX_ND_HI_A) begin
        rdata_next = {nd_reg[15:12], hi_same ? nd_reg[11:8] : NIB_ONES};
      end else if (ridx == IDX_ND_HI_B) begin
        rdata_next = hi_same ? BYTE_ONES : {NIB_ONES, nd_reg[11:8]};
      end else if (ridx == IDX_PORT_STAT) begin
        rdata_next = port_reg[7:0];
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && RREADY) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      trig_sel_reg <= RST_TRIG_SEL;
      en_hi_reg <= RST_EN;
      en_lo_reg <= RST_EN;
      nd_reg <= RST_ND;
      port_reg <= RST_PORT;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      waddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= RESP_OKAY;
    end else begin
      trig_sel_reg <= trig_sel_next;
      en_hi_reg <= en_hi_next;
      en_lo_reg <= en_lo_next;
      nd_reg <= nd_next;
      port_reg <= port_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign PORTA_OUT = port_reg[7:0];
  assign PORTB_OUT = port_reg[15:8];
  assign PORTA_OE = en_lo_reg;
  assign PORTB_OE = en_hi_reg;
  assign AWREADY = awready_reg;
  assign WREADY = wready_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign ARREADY = arready_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = {24'h000000, rdata_reg};
  assign RRESP = rresp_reg;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  chk_grp0_chan0: assert property (
    (trig_sel_reg[1:0] == 2'b00 && CMP_MATCH[0] && en_lo_reg[0])
    |=> PORTA_OUT[0] == $past(nd_reg[0]))
    else $error("group 0 missed channel 0 trigger");
  chk_grp1_chan1: assert property (
    (trig_sel_reg[3:2] == 2'b01 && CMP_MATCH[1] && en_lo_reg[4])
    |=> PORTA_OUT[4] == $past(nd_reg[4]))
    else $error("group 1 missed channel 1 trigger");
  chk_grp2_chan2: assert property (
    (trig_sel_reg[5] && CMP_MATCH[2] && en_hi_reg[0])
    |=> PORTB_OUT[0] == $past(nd_reg[8]))
    else $error("group 2 missed channel 2 trigger");
  chk_grp3_chan0: assert property (
    (trig_sel_reg[7:6] == 2'b00 && CMP_MATCH[0] && en_hi_reg[7])
    |=> PORTB_OUT[7] == $past(nd_reg[15]))
    else $error("group 3 missed channel 0 trigger");
  chk_upper_block: assert property (
    !en_hi_reg[3] |=> $stable(PORTB_OUT[3]))
    else $error("disabled port B bit changed");
  chk_lower_block: assert property (
    !en_lo_reg[2] |=> $stable(PORTA_OUT[2]))
    else $error("disabled port A bit changed");
  chk_shared_byte: assert property (
    (wr_do && wstrb_reg && waddr_reg == IDX_ND_LO_A && lo_same)
    |=> nd_reg[7:0] == $past(wdata_reg))
    else $error("shared next data byte not written");
  chk_split_byte: assert property (
    (wr_do && waddr_reg == IDX_ND_LO_A && !lo_same)
    |=> nd_reg[3:0] == $past(nd_reg[3:0]))
    else $error("group 0 data changed through group 1 byte");
  chk_sel_write: assert property (
    (wr_do && wstrb_reg && waddr_reg == IDX_TRIG_SEL)
    |=> trig_sel_reg == $past(wdata_reg) && BVALID)
    else $error("trigger select write lost");
  chk_no_match: assert property (
    CMP_MATCH == 3'b000 |=> $stable(port_reg))
    else $error("port changed without compare match");
  cov_shared_fire: cover property (lo_same && fire[0] && en_lo_reg != 8'h00);
  cov_split_fire: cover property (!lo_same && fire[1] && !fire[0]);
  cov_bad_addr: cover property (RVALID && RRESP == RESP_SLVERR);
endmodule // tpo_unit

// ---- common/tpo_pkg.sv ----
// constants and register map of the timed pattern output unit
package tpo_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int IDX_W = 20;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TRIG_SEL = 20'hFFFA1;
  localparam logic [IDX_W-1:0] IDX_EN_HI = 20'hFFFA2;
  localparam logic [IDX_W-1:0] IDX_EN_LO = 20'hFFFA3;
  localparam logic [IDX_W-1:0] IDX_ND_LO_A = 20'hFFFA5;
  localparam logic [IDX_W-1:0] IDX_ND_LO_B = 20'hFFFA7;
  localparam logic [IDX_W-1:0] IDX_ND_HI_A = 20'hFFFA8;
  localparam logic [IDX_W-1:0] IDX_ND_HI_B = 20'hFFFA9;
  localparam logic [IDX_W-1:0] IDX_PORT_STAT = 20'hFFFAA;
  // reset values
  localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [15:0] RST_ND = 16'h0000;
  localparam logic [15:0] RST_PORT = 16'h0000;
  // unused nibbles of next-data locations read as ones
  localparam logic [3:0] NIB_ONES = 4'hF;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  // select field encodings
  localparam int SEL_HI_BIT = 1;
  localparam int SEL_LO_BIT = 0;
  localparam int GROUPS = 4;
  localparam int GRP_BITS = 4;
  localparam int CHANNELS = 3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- sim/tpo_pins.sv ----
// pin-level model of the pattern output ports
`timescale 1ns/100ps
module tpo_pins (
  // pattern drive from the unit
  input wire logic [15:0] pat_out,
  input wire logic [15:0] pat_oe,
  // resolved pin levels
  output logic [15:0] pin_level
);
  logic [15:0] last_reg = 16'h0000;
  // an undriven pin floats away from its last driven value
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_level[i] = pat_oe[i] ? pat_out[i] : ~last_reg[i];
    end
  end
  always @(pat_out) last_reg = pat_out;
endmodule // tpo_pins

// ---- sim/testbench.sv ----
// self-checking bench of the timed pattern output unit
`timescale 1ns/100ps
module testbench;
  import tpo_pkg::*;
  logic CLOCK = 0;
  logic NRST = 0;
  logic [2:0] CMP_MATCH = 3'h0;
  logic [7:0] PORTA_OUT, PORTB_OUT, PORTA_OE, PORTB_OE;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
  logic [DATA_W-1:0] WDATA = '0, RDATA;
  logic [1:0] BRESP, RRESP;
  logic [15:0] pins, en, nd, port;
  logic [33:0] exp_q[$];
  logic [7:0] sel, a_lo, b_lo, a_hi, b_hi;
  int errors = 0, checked = 0, cyc = 0, seed = 8;
  always #2.5 CLOCK = ~CLOCK;
  tpo_unit u_tpo_unit (.CLOCK(CLOCK), .NRST(NRST), .CMP_MATCH(CMP_MATCH),
    .PORTA_OUT(PORTA_OUT), .PORTB_OUT(PORTB_OUT), .PORTA_OE(PORTA_OE),
    .PORTB_OE(PORTB_OE), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(4'hF), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP));
  tpo_pins u_tpo_pins (.pat_out({PORTB_OUT, PORTA_OUT}),
    .pat_oe({PORTB_OE, PORTA_OE}), .pin_level(pins));
  task chk(input logic [33:0] seen, input logic [33:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [19:0] idx, input logic [7:0] d, input logic [1:0] rs);
    logic ga, gw, ta, tw;
    ga = 0;
    gw = 0;
    exp_q.push_back({rs, 32'h0});
    @(posedge CLOCK);
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    AWADDR <= {idx, 2'b00};
    WDATA <= {24'h0, d};
    while (!(ga && gw)) begin
      @(negedge CLOCK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CLOCK);
      if (ta) AWVALID <= 0;
      if (tw) WVALID <= 0;
      ga |= ta;
      gw |= tw;
    end
    do @(negedge CLOCK); while (!BVALID);
    @(posedge CLOCK);
    BREADY <= 0;
  endtask
  task rd(input logic [19:0] idx, input logic [33:0] want);
    exp_q.push_back(want);
    @(posedge CLOCK);
    ARVALID <= 1;
    ARADDR <= {idx, 2'b00};
    RREADY <= 1;
    do @(negedge CLOCK); while (!ARREADY);
    @(posedge CLOCK);
    ARVALID <= 0;
    do @(negedge CLOCK); while (!RVALID);
    @(posedge CLOCK);
    RREADY <= 0;
  endtask
  // one timer channel fires; the enabled bits of every group selecting it take their next data
  task pulse(input int c);
    logic [15:0] m;
    @(posedge CLOCK);
    CMP_MATCH <= 3'h1 << c;
    for (int g = 0; g < 4; g++) begin
      m = en & (16'h000F << (4 * g));
      if ((sel[2*g+1] ? 2 : int'(sel[2*g])) == c) port = (port & ~m) | (nd & m);
    end
    @(posedge CLOCK);
    CMP_MATCH <= 3'h0;
    #1;
    chk({18'h0, PORTB_OUT, PORTA_OUT}, {18'h0, port});
    chk({18'h0, pins & en}, {18'h0, port & en});
    chk({18'h0, PORTB_OE, PORTA_OE}, {18'h0, en});
  endtask
  // bus answers are compared in the order they were requested
  always @(negedge CLOCK) begin
    if ((BVALID && BREADY) || (RVALID && RREADY)) begin
      if (BVALID) chk({BRESP, 32'h0}, exp_q.pop_front());
      else chk({RRESP, RDATA}, exp_q.pop_front());
    end
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    NRST <= 1;
    port = 16'h0000;
    rd(IDX_TRIG_SEL, {2'b00, 32'hFF});
    rd(IDX_EN_HI, 34'h0);
    rd(IDX_EN_LO, 34'h0);
    rd(IDX_ND_LO_A, 34'h0);
    rd(20'hFFFA6, {RESP_SLVERR, 32'h0});
    wr(20'hFFFA6, 8'h5A, RESP_SLVERR);
    for (int s = 0; s < 12; s++) begin
      sel = 8'($random(seed));
      {en, a_lo, b_lo} = $random(seed);
      {a_hi, b_hi} = 16'($random(seed));
      wr(IDX_TRIG_SEL, sel, RESP_OKAY);
      wr(IDX_EN_HI, en[15:8], RESP_OKAY);
      wr(IDX_EN_LO, en[7:0], RESP_OKAY);
      wr(IDX_ND_LO_A, a_lo, RESP_OKAY);
      wr(IDX_ND_LO_B, b_lo, RESP_OKAY);
      wr(IDX_ND_HI_A, a_hi, RESP_OKAY);
      wr(IDX_ND_HI_B, b_hi, RESP_OKAY);
      nd[7:0] = (sel[1:0] == sel[3:2]) ? a_lo : {a_lo[7:4], b_lo[3:0]};
      nd[15:8] = (sel[5:4] == sel[7:6]) ? a_hi : {a_hi[7:4], b_hi[3:0]};
      rd(IDX_TRIG_SEL, {26'h0, sel});
      rd(IDX_EN_HI, {26'h0, en[15:8]});
      rd(IDX_EN_LO, {26'h0, en[7:0]});
      rd(IDX_ND_LO_A, {26'h0, (sel[1:0] == sel[3:2]) ? a_lo
        : {a_lo[7:4], 4'hF}});
      rd(IDX_ND_LO_B, {26'h0, (sel[1:0] == sel[3:2]) ? 8'hFF
        : {4'hF, b_lo[3:0]}});
      rd(IDX_ND_HI_A, {26'h0, (sel[5:4] == sel[7:6]) ? a_hi
        : {a_hi[7:4], 4'hF}});
      rd(IDX_ND_HI_B, {26'h0, (sel[5:4] == sel[7:6]) ? 8'hFF
        : {4'hF, b_hi[3:0]}});
      for (int c = 0; c < 3; c++) pulse(c);
      rd(IDX_PORT_STAT, {26'h0, port[7:0]});
    end
    test_done;
  end
endmodule // testbench
